// ### verilog/core_ops_pkg.sv
// Constants, opcodes, register map and state type for the core op decoder
//**********************************************************************
//**********************************************************************
package core_ops_pkg;
   localparam int unsigned INSTR_W      = 14;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned PC_W         = 13;
   localparam int unsigned FADDR_W      = 7;
   localparam int unsigned STACK_DEPTH  = 8;
   localparam int unsigned STACK_PTR_W  = 3;
   localparam int unsigned FLAG_W       = 5;
   localparam int unsigned EV_W         = 5;
   localparam int unsigned APB_AW       = 8;
   localparam int unsigned APB_DW       = 32;

   // Opcode fields
   localparam logic [13:0] OP_RETURN    = 14'h0008;
   localparam logic [13:0] OP_SLEEP     = 14'h0063;
   localparam logic [5:0]  OP_ROT_LEFT  = 6'h0d;
   localparam logic [5:0]  OP_ROT_RIGHT = 6'h0c;
   localparam int unsigned OPC_HI       = 13;
   localparam int unsigned OPC_LO       = 8;
   localparam int unsigned DEST_BIT     = 7;

   // Register offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_FLAGS     = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
   localparam logic [7:0] REG_ACC       = 8'h10;
   localparam logic [7:0] REG_PC        = 8'h14;

   // Flag layout: carry, digit carry, zero, sleep entered, expiry
   localparam int unsigned FLG_C        = 0;
   localparam int unsigned FLG_DC       = 1;
   localparam int unsigned FLG_Z        = 2;
   localparam int unsigned FLG_PD       = 3;
   localparam int unsigned FLG_TO       = 4;
   localparam logic [4:0] FLAGS_RST     = 5'h18;

   // Event layout
   localparam int unsigned EV_RET       = 0;
   localparam int unsigned EV_ROT       = 1;
   localparam int unsigned EV_SLEEP     = 2;
   localparam int unsigned EV_WAKE      = 3;
   localparam int unsigned EV_WDT       = 4;

   localparam int unsigned CTRL_EN      = 0;
   localparam logic        CTRL_EN_RST  = 1'h1;
   localparam logic [12:0] PC_RST       = 13'h0000;
   localparam logic [12:0] PC_STEP      = 13'h0001;
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic [7:0]  WDT_ZERO     = 8'h00;
   localparam logic [7:0]  WDT_STEP     = 8'h01;
   localparam logic [7:0]  WDT_MAX      = 8'hff;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_RET   = 2'b01,
      ST_SLEEP = 2'b11
   } exec_state_t;
endpackage

// ### verilog/rotate_carry_unit.sv
// Rotate through carry datapath, one direction select
`timescale 1ns/10ps
module rotate_carry_unit
(
   input  wire logic [7:0] data_i,
   input  wire logic       carry_i,
   input  wire logic       left_i,
   output logic      [7:0] result_o,
   output logic            carry_o
);
   always_comb
   begin
      if (left_i)
      begin
         result_o = {data_i[6:0], carry_i};
         carry_o  = data_i[7];
      end
      else
      begin
         result_o = {carry_i, data_i[7:1]};
         carry_o  = data_i[0];
      end
   end
endmodule // rotate_carry_unit

// ### verilog/return_stack.sv
// Eight level circular return address stack
`timescale 1ns/10ps
module return_stack
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        push_i,
   input  wire logic [12:0] push_data_i,
   input  wire logic        pop_i,
   output logic      [12:0] top_o
);
   // Overflow wraps silently, as the real stack has no full flag
   logic [12:0] mem_q [core_ops_pkg::STACK_DEPTH];
   logic [2:0]  ptr_q;
   logic [2:0]  ptr_d;

   always_comb
   begin
      ptr_d = ptr_q;
      if (push_i && !pop_i)
         ptr_d = ptr_q + 3'h1;
      else if (pop_i && !push_i)
         ptr_d = ptr_q - 3'h1;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ptr_q <= 3'h0;
      else
         ptr_q <= ptr_d;
   end

   always_ff @(posedge mclk_i)
   begin
      if (push_i && !pop_i)
         mem_q[ptr_q] <= push_data_i;
   end

   assign top_o = mem_q[ptr_q - 3'h1];
endmodule // return_stack

// ### verilog/core_ops_decoder.sv
// Return, rotate and sleep execution with APB status registers
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module core_ops_decoder
#(
   parameter logic [7:0] WDT_PRE_TOP = core_ops_pkg::WDT_MAX
)
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        instr_valid_i,
   input  wire logic [13:0] instr_i,
   input  wire logic [7:0]  operand_i,
   input  wire logic        call_push_i,
   input  wire logic [12:0] call_pc_i,
   input  wire logic        wake_pin_i,
   output logic             instr_ready_o,
   output logic      [12:0] pc_o,
   output logic      [7:0]  acc_o,
   output logic             file_wr_o,
   output logic      [6:0]  file_addr_o,
   output logic      [7:0]  file_wdata_o,
   output logic             osc_run_o,
   output logic             wdt_clear_o,
   output logic             irq_o
);
   //*******************************************************************
   // Declarations
   //*******************************************************************
   core_ops_pkg::exec_state_t state_q, state_d;
   logic [12:0] pc_q, pc_d, stack_top;
   logic [7:0]  acc_q, acc_d, rot_res;
   logic [4:0]  flags_q, flags_d;
   logic [4:0]  stat_q, stat_d, mask_q, mask_d, ev;
   logic        ready_q, ready_d, wr_q, wr_d, wclr_q, wclr_d;
   logic        osc_q, osc_d, irq_q, irq_d, en_q, en_d;
   logic [6:0]  waddr_q, waddr_d;
   logic [7:0]  wdata_q, wdata_d;
   logic [7:0]  pre_q, pre_d, cnt_q, cnt_d;
   logic        wake_s1_q, wake_s2_q, pop, accept, is_rot, expire;
   logic        rot_carry, apb_acc, apb_wr, flags_wr, hit;
   logic        pready_q, pready_d, perr_q, perr_d;
   logic [31:0] prdata_q, prdata_d, rd;

   assign accept  = instr_valid_i && ready_q;
   assign is_rot  = (instr_i[core_ops_pkg::OPC_HI:core_ops_pkg::OPC_LO]
                     == core_ops_pkg::OP_ROT_LEFT) ||
                    (instr_i[core_ops_pkg::OPC_HI:core_ops_pkg::OPC_LO]
                     == core_ops_pkg::OP_ROT_RIGHT);
   assign expire  = (pre_q == WDT_PRE_TOP) &&
                    (cnt_q == core_ops_pkg::WDT_MAX);

   return_stack u_stack
   (
      .mclk_i      (mclk_i),
      .rst_b_i     (rst_b_i),
      .push_i      (call_push_i),
      .push_data_i (call_pc_i),
      .pop_i       (pop),
      .top_o       (stack_top)
   );

   rotate_carry_unit u_rot
   (
      .data_i   (operand_i),
      .carry_i  (flags_q[core_ops_pkg::FLG_C]),
      .left_i   (instr_i[core_ops_pkg::OPC_HI:core_ops_pkg::OPC_LO]
                 == core_ops_pkg::OP_ROT_LEFT),
      .result_o (rot_res),
      .carry_o  (rot_carry)
   );

   //*******************************************************************
   // Wake pin synchroniser
   //*******************************************************************
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wake_s1_q <= 1'h0;
         wake_s2_q <= 1'h0;
      end
      else
      begin
         wake_s1_q <= wake_pin_i;
         wake_s2_q <= wake_s1_q;
      end
   end

   //*******************************************************************
   // Instruction execution
   //*******************************************************************
   always_comb
   begin
      state_d = state_q;
      pc_d    = pc_q;
      acc_d   = acc_q;
      flags_d = flags_q;
      wr_d    = 1'h0;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wclr_d  = 1'h0;
      pop     = 1'h0;
      ev      = '0;
      // Software write first so a same-cycle hardware update wins
      if (flags_wr)
         flags_d[core_ops_pkg::FLG_Z:core_ops_pkg::FLG_C] =
            pwdata_i[core_ops_pkg::FLG_Z:core_ops_pkg::FLG_C];
      if (expire)
      begin
         flags_d[core_ops_pkg::FLG_TO] = 1'h0;
         ev[core_ops_pkg::EV_WDT]      = 1'h1;
      end
      case (state_q)
         core_ops_pkg::ST_RUN:
         begin
            if (accept && instr_i == core_ops_pkg::OP_RETURN)
            begin
               pop     = 1'h1;
               pc_d    = stack_top;
               state_d = core_ops_pkg::ST_RET;
               ev[core_ops_pkg::EV_RET] = 1'h1;
            end
            else if (accept && instr_i == core_ops_pkg::OP_SLEEP)
            begin
               flags_d[core_ops_pkg::FLG_PD] = 1'h0;
               flags_d[core_ops_pkg::FLG_TO] = 1'h1;
               wclr_d  = 1'h1;
               state_d = core_ops_pkg::ST_SLEEP;
               pc_d    = pc_q + core_ops_pkg::PC_STEP;
               ev[core_ops_pkg::EV_SLEEP] = 1'h1;
            end
            else if (accept && is_rot)
            begin
               // Only carry changes; zero and digit carry untouched
               flags_d[core_ops_pkg::FLG_C] = rot_carry;
               if (instr_i[core_ops_pkg::DEST_BIT])
               begin
                  wr_d    = 1'h1;
                  waddr_d = instr_i[6:0];
                  wdata_d = rot_res;
               end
               else
                  acc_d = rot_res;
               pc_d = pc_q + core_ops_pkg::PC_STEP;
               ev[core_ops_pkg::EV_ROT] = 1'h1;
            end
            else if (accept)
               pc_d = pc_q + core_ops_pkg::PC_STEP;
         end
         core_ops_pkg::ST_RET:
            state_d = core_ops_pkg::ST_RUN;
         core_ops_pkg::ST_SLEEP:
         begin
            if (wake_s2_q || expire)
            begin
               state_d = core_ops_pkg::ST_RUN;
               ev[core_ops_pkg::EV_WAKE] = 1'h1;
            end
         end
         default:
            state_d = core_ops_pkg::ST_RUN;
      endcase
      ready_d = (state_d == core_ops_pkg::ST_RUN) && en_q;
      osc_d   = (state_d != core_ops_pkg::ST_SLEEP);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= core_ops_pkg::ST_RUN;
         pc_q    <= core_ops_pkg::PC_RST;
         acc_q   <= core_ops_pkg::ACC_RST;
         flags_q <= core_ops_pkg::FLAGS_RST;
         wr_q    <= 1'h0;
         waddr_q <= 7'h00;
         wdata_q <= 8'h00;
         wclr_q  <= 1'h0;
         ready_q <= 1'h0;
         osc_q   <= 1'h1;
      end
      else
      begin
         state_q <= state_d;
         pc_q    <= pc_d;
         acc_q   <= acc_d;
         flags_q <= flags_d;
         wr_q    <= wr_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wclr_q  <= wclr_d;
         ready_q <= ready_d;
         osc_q   <= osc_d;
      end
   end

   //*******************************************************************
   // Watchdog counter and prescaler
   //*******************************************************************
   always_comb
   begin
      pre_d = pre_q + core_ops_pkg::WDT_STEP;
      cnt_d = cnt_q;
      if (pre_q == WDT_PRE_TOP)
      begin
         pre_d = core_ops_pkg::WDT_ZERO;
         cnt_d = cnt_q + core_ops_pkg::WDT_STEP;
      end
      if (wclr_d)
      begin
         pre_d = core_ops_pkg::WDT_ZERO;
         cnt_d = core_ops_pkg::WDT_ZERO;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pre_q <= core_ops_pkg::WDT_ZERO;
         cnt_q <= core_ops_pkg::WDT_ZERO;
      end
      else
      begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
      end
   end

   //*******************************************************************
   // APB slave, two-cycle access, write commits with pready
   //*******************************************************************
   assign apb_acc  = psel_i && penable_i && !pready_q;
   assign apb_wr   = psel_i && penable_i && pready_q && pwrite_i && !perr_q;
   assign flags_wr = apb_wr && (paddr_i == core_ops_pkg::REG_FLAGS);

   always_comb
   begin
      hit = 1'h1;
      rd  = '0;
      if (paddr_i == core_ops_pkg::REG_CTRL)
         rd[core_ops_pkg::CTRL_EN] = en_q;
      else if (paddr_i == core_ops_pkg::REG_FLAGS)
         rd[4:0] = flags_q;
      else if (paddr_i == core_ops_pkg::REG_IRQ_STAT)
         rd[4:0] = stat_q;
      else if (paddr_i == core_ops_pkg::REG_IRQ_MASK)
         rd[4:0] = mask_q;
      else if (paddr_i == core_ops_pkg::REG_ACC)
         rd[7:0] = acc_q;
      else if (paddr_i == core_ops_pkg::REG_PC)
         rd[12:0] = pc_q;
      else
         hit = 1'h0;
      pready_d = apb_acc;
      perr_d   = apb_acc && !hit;
      prdata_d = (apb_acc && !pwrite_i) ? rd : '0;
      en_d     = en_q;
      mask_d   = mask_q;
      if (apb_wr && paddr_i == core_ops_pkg::REG_CTRL)
         en_d = pwdata_i[core_ops_pkg::CTRL_EN];
      if (apb_wr && paddr_i == core_ops_pkg::REG_IRQ_MASK)
         mask_d = pwdata_i[4:0];
      // Set wins over a same-cycle write-one clear
      stat_d = stat_q;
      if (apb_wr && paddr_i == core_ops_pkg::REG_IRQ_STAT)
         stat_d = stat_q & ~pwdata_i[4:0];
      stat_d = stat_d | ev;
      irq_d  = |(stat_d & mask_d);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pready_q <= 1'h0;
         perr_q   <= 1'h0;
         prdata_q <= 32'h0000_0000;
         en_q     <= core_ops_pkg::CTRL_EN_RST;
         mask_q   <= 5'h00;
         stat_q   <= 5'h00;
         irq_q    <= 1'h0;
      end
      else
      begin
         pready_q <= pready_d;
         perr_q   <= perr_d;
         prdata_q <= prdata_d;
         en_q     <= en_d;
         mask_q   <= mask_d;
         stat_q   <= stat_d;
         irq_q    <= irq_d;
      end
   end

   assign prdata_o      = prdata_q;
   assign pready_o      = pready_q;
   assign pslverr_o     = perr_q;
   assign instr_ready_o = ready_q;
   assign pc_o          = pc_q;
   assign acc_o         = acc_q;
   assign file_wr_o     = wr_q;
   assign file_addr_o   = waddr_q;
   assign file_wdata_o  = wdata_q;
   assign osc_run_o     = osc_q;
   assign wdt_clear_o   = wclr_q;
   assign irq_o         = irq_q;

   //*******************************************************************
   // Assertions
   //*******************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   logic do_ret, do_slp, do_rl, do_rr;
   assign do_ret = accept && state_q == core_ops_pkg::ST_RUN &&
                   instr_i == core_ops_pkg::OP_RETURN;
   assign do_slp = accept && state_q == core_ops_pkg::ST_RUN &&
                   instr_i == core_ops_pkg::OP_SLEEP;
   assign do_rl  = accept && state_q == core_ops_pkg::ST_RUN &&
                   instr_i[13:8] == core_ops_pkg::OP_ROT_LEFT;
   assign do_rr  = accept && state_q == core_ops_pkg::ST_RUN &&
                   instr_i[13:8] == core_ops_pkg::OP_ROT_RIGHT;

   ret_two_cycle_a: assert property (
      do_ret |=> !instr_ready_o ##1 state_q == core_ops_pkg::ST_RUN)
      else $error("return did not take two cycles");
   ret_pc_load_a: assert property (
      do_ret && !flags_wr |=> pc_o == $past(stack_top) &&
                              flags_q == $past(flags_q))
      else $error("return did not load stack top or changed flags");
   left_rotate_a: assert property (
      do_rl && !instr_i[7] |=>
         acc_o == {$past(operand_i[6:0]), $past(flags_q[0])} &&
         flags_q[0] == $past(operand_i[7]))
      else $error("left rotate result wrong");
   right_rotate_a: assert property (
      do_rr && instr_i[7] |=> file_wr_o &&
         file_wdata_o == {$past(flags_q[0]), $past(operand_i[7:1])} &&
         flags_q[0] == $past(operand_i[0]))
      else $error("right rotate result wrong");
   rot_dest_acc_a: assert property (
      (do_rl || do_rr) && !instr_i[7] |=> !file_wr_o &&
         file_addr_o == $past(file_addr_o))
      else $error("accumulator destination wrote the file");
   rot_one_cycle_a: assert property (
      (do_rl || do_rr) |=> state_q == core_ops_pkg::ST_RUN &&
         pc_o == $past(pc_o) + core_ops_pkg::PC_STEP)
      else $error("rotate did not finish in one cycle");
   sleep_pd_a: assert property (
      do_slp |=> !flags_q[core_ops_pkg::FLG_PD])
      else $error("sleep left sleep entered flag set");
   sleep_to_a: assert property (
      do_slp && !expire |=> flags_q[core_ops_pkg::FLG_TO])
      else $error("sleep did not set expiry flag");
   sleep_wdt_a: assert property (
      do_slp |=> wdt_clear_o && pre_q == core_ops_pkg::WDT_ZERO &&
                 cnt_q == core_ops_pkg::WDT_ZERO)
      else $error("sleep did not clear watchdog");
   sleep_halt_a: assert property (
      do_slp |=> !osc_run_o && !instr_ready_o)
      else $error("sleep did not halt the core");
   rot_flags_a: assert property (
      (do_rl || do_rr) && !flags_wr |=>
         flags_q[2:1] == $past(flags_q[2:1]))
      else $error("rotate changed zero or digit carry");

   ret_seen_c:   cover property (do_ret ##2 accept);
   rot_file_c:   cover property (do_rl && instr_i[7]);
   sleep_wake_c: cover property (do_slp ##[1:40] osc_run_o);
endmodule // core_ops_decoder

// ### verif/tb_top.sv
// Self-checking bench for the return, rotate and sleep decoder
`timescale 1ns/10ps
module tb_top;
   //*******************************************************************
   // Signals
   //*******************************************************************
   logic        mclk_i, rst_b_i, psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        pready_o, pslverr_o, instr_valid_i, call_push_i;
   logic [13:0] instr_i;
   logic [7:0]  operand_i, acc_o, file_wdata_o;
   logic [12:0] call_pc_i, pc_o, p1, p2;
   logic        wake_pin_i, instr_ready_o, file_wr_o, osc_run_o;
   logic        wdt_clear_o, irq_o, erv, lf, dd, cc;
   logic [6:0]  file_addr_o, fa;
   logic [31:0] rdv;
   logic [4:0]  ef;
   logic [8:0]  ex;
   logic [7:0]  dv;
   int          n_errors, num_checks;
   int          cyc = 0;

   // Short watchdog prescaler keeps the expiry inside the run
   core_ops_decoder #(.WDT_PRE_TOP(8'h03)) core_ops_decoder_i (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .operand_i(operand_i),
      .call_push_i(call_push_i), .call_pc_i(call_pc_i),
      .wake_pin_i(wake_pin_i), .instr_ready_o(instr_ready_o),
      .pc_o(pc_o), .acc_o(acc_o), .file_wr_o(file_wr_o),
      .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
      .osc_run_o(osc_run_o), .wdt_clear_o(wdt_clear_o), .irq_o(irq_o));

   always #5 mclk_i = ~mclk_i;

   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   //*******************************************************************
   // Helpers
   //*******************************************************************
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Entered just after a rising edge; one idle cycle follows
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      // Hold the request until pready is seen at a rising edge
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rdv = prdata_o;
      erv = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   // Offer stands until ready is seen high at a rising edge
   task automatic exec(input logic [13:0] op, input logic [7:0] v);
      instr_valid_i <= 1'b1;
      instr_i <= op;
      operand_i <= v;
      do @(posedge mclk_i); while (instr_ready_o !== 1'b1);
      instr_valid_i <= 1'b0;
   endtask

   task automatic push(input logic [12:0] v);
      call_push_i <= 1'b1;
      call_pc_i <= v;
      @(posedge mclk_i);
      call_push_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   function automatic logic [8:0] rot(input logic l, input logic [7:0] v,
                                      input logic c);
      rot = l ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
   endfunction

   //*******************************************************************
   // Main sequence
   //*******************************************************************
   initial
   begin
      {mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, paddr_i} = '0;
      {pwdata_i, instr_valid_i, instr_i, operand_i} = '0;
      {call_push_i, call_pc_i, wake_pin_i} = '0;
      n_errors = 0;
      num_checks = 0;
      void'($urandom(54));
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      apb(1'b0, core_ops_pkg::REG_FLAGS, 32'h0);
      chk("flags_rst", 32'h18, rdv);
      apb(1'b0, core_ops_pkg::REG_IRQ_MASK, 32'h0);
      chk("mask_rst", 32'h0, rdv);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, erv});
      chk("unmapped_rd", 32'h0, rdv);
      ef = 5'h18;
      // Rotates in every direction and destination, fixed data 8'he6 on the first two, then random
      for (int i = 0; i < 8; i++)
      begin
         lf = i[0];
         dd = i[1];
         dv = (i < 2) ? 8'he6 : 8'($urandom);
         cc = (i < 2) ? 1'b0 : 1'($urandom);
         fa = 7'($urandom);
         ef[2:0] = {2'($urandom), cc};
         apb(1'b1, core_ops_pkg::REG_FLAGS, {27'h0, ef});
         ex = rot(lf, dv, cc);
         exec({lf ? core_ops_pkg::OP_ROT_LEFT : core_ops_pkg::OP_ROT_RIGHT,
               dd, fa}, dv);
         @(negedge mclk_i);
         chk("rot_ready", 32'h1, {31'h0, instr_ready_o});
         chk("rot_wr", {31'h0, dd}, {31'h0, file_wr_o});
         if (dd)
         begin
            chk("rot_faddr", {25'h0, fa}, {25'h0, file_addr_o});
            chk("rot_file", {24'h0, ex[7:0]}, {24'h0, file_wdata_o});
         end
         else
            chk("rot_acc", {24'h0, ex[7:0]}, {24'h0, acc_o});
         @(posedge mclk_i);
         ef[0] = ex[8];
         apb(1'b0, core_ops_pkg::REG_FLAGS, 32'h0);
         chk("rot_flags", {27'h0, ef}, rdv);
      end
      // Two nested returns come back in last-in order
      p1 = 13'($urandom);
      p2 = 13'($urandom);
      push(p1);
      push(p2);
      for (int i = 0; i < 2; i++)
      begin
         exec(core_ops_pkg::OP_RETURN, 8'h00);
         @(negedge mclk_i);
         chk("ret_pc", {19'h0, (i == 0) ? p2 : p1}, {19'h0, pc_o});
         chk("ret_busy", 32'h0, {31'h0, instr_ready_o});
         @(negedge mclk_i);
         chk("ret_done", 32'h1, {31'h0, instr_ready_o});
         @(posedge mclk_i);
      end
      apb(1'b0, core_ops_pkg::REG_FLAGS, 32'h0);
      chk("ret_flags", {27'h0, ef}, rdv);
      // Sleep, stay asleep, then wake from the pin
      exec(core_ops_pkg::OP_SLEEP, 8'h00);
      @(negedge mclk_i);
      chk("slp_osc", 32'h0, {31'h0, osc_run_o});
      chk("slp_ready", 32'h0, {31'h0, instr_ready_o});
      chk("slp_wdt", 32'h1, {31'h0, wdt_clear_o});
      @(negedge mclk_i);
      chk("slp_wdt_pulse", 32'h0, {31'h0, wdt_clear_o});
      @(posedge mclk_i);
      apb(1'b0, core_ops_pkg::REG_FLAGS, 32'h0);
      chk("slp_flags", {27'h0, 2'b10, ef[2:0]}, rdv);
      @(negedge mclk_i);
      chk("slp_hold", 32'h0, {31'h0, osc_run_o});
      @(posedge mclk_i);
      wake_pin_i <= 1'b1;
      for (int i = 0; i < 8 && osc_run_o !== 1'b1; i++)
         @(negedge mclk_i);
      chk("wake_osc", 32'h1, {31'h0, osc_run_o});
      @(posedge mclk_i);
      wake_pin_i <= 1'b0;
      // Interrupt status, mask and clear
      apb(1'b0, core_ops_pkg::REG_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h0f, rdv);
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      apb(1'b1, core_ops_pkg::REG_IRQ_MASK, 32'h04);
      @(negedge mclk_i);
      chk("irq_on", 32'h1, {31'h0, irq_o});
      @(posedge mclk_i);
      apb(1'b1, core_ops_pkg::REG_IRQ_STAT, 32'h04);
      @(negedge mclk_i);
      chk("irq_off", 32'h0, {31'h0, irq_o});
      @(posedge mclk_i);
      apb(1'b0, core_ops_pkg::REG_IRQ_STAT, 32'h0);
      chk("irq_w1c", 32'h0, rdv & 32'h04);
      // Disabled core refuses instructions
      apb(1'b1, core_ops_pkg::REG_CTRL, 32'h0);
      @(negedge mclk_i);
      chk("ctrl_off", 32'h0, {31'h0, instr_ready_o});
      @(posedge mclk_i);
      apb(1'b1, core_ops_pkg::REG_CTRL, 32'h1);
      // Watchdog expiry wakes from sleep and clears the expiry flag
      exec(core_ops_pkg::OP_SLEEP, 8'h00);
      @(negedge mclk_i);
      chk("wdt_sleep", 32'h0, {31'h0, osc_run_o});
      for (int i = 0; i < 1100 && osc_run_o !== 1'b1; i++)
         @(negedge mclk_i);
      chk("wdt_wake", 32'h1, {31'h0, osc_run_o});
      @(posedge mclk_i);
      apb(1'b0, core_ops_pkg::REG_FLAGS, 32'h0);
      chk("wdt_flags", {27'h0, 2'b00, ef[2:0]}, rdv);
      apb(1'b0, core_ops_pkg::REG_IRQ_STAT, 32'h0);
      chk("wdt_stat", 32'h10, rdv & 32'h10);
      report_and_stop();
   end
endmodule // tb_top
